// ==== logic/mtp_buf.sv ====
`timescale 1ns/1ps
module mtp_buf #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  store [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   // honest full and empty
   assign in_ready  = cnt_q != CW'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = store[rd_q];

   // storage, pointers and fill count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            store[wr_q] <= in_data;
            wr_q        <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
         end
         cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
      end
   end
endmodule : mtp_buf

// ==== logic/mtp_terminal.sv ====
// Behaviour
// - data bus driven only during own writes
// - transmit flag high exactly while sending
// - reset clears the error flags
// - true rail positive, complement rail negative
// - mode flag on subaddress all ones/zeros
// - write strobe low only with stable data
// - valid command pulsed high per error-free addressed command
// - direction high on reads, low on writes
// - message error pulses with message complete
// - bad addressed command pulses invalid only
// - message complete signals the end of every started message not cut short by a new command or status word
// - command error resets receiver, resumes sync search
// - role select high terminal, low controller
`timescale 1ns/1ps
`include "mtp_defs.svh"
module mtp_terminal (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire mtp_pkg::mtp_rx_pair_t manchester_rx_pair,
   input  wire logic                 role_select,
   input  wire logic [4:0]           rt_address,
   input  wire logic                 rt_address_load,
   input  wire logic                 mem_ack,
   input  wire logic [15:0]          mem_din,
   output mtp_pkg::mtp_mem_out_t     mem_q,
   output logic                      transmit_active,
   output logic                      mode_command_flag,
   output logic                      valid_command_pulse,
   output logic                      invalid_message_n,
   output logic                      message_complete_n,
   output logic [3:0]                error_flags,
   output logic [15:0]               tx_word
);
   import mtp_pkg::*;

   mtp_rx_state_t         rx_q, rx_d;
   mtp_dma_state_t        dm_q;
   logic [`MTP_TW-1:0]    cyc_q, cyc_d, gap_q, txc_q;
   logic [4:0]            nbit_q, addr_q;
   logic [16:0]           shift_q;
   logic                  sync_cmd_q, h1_q, man_q, word_v_q, addr_ok_q;
   logic                  in_msg_q, msg_err_q, bcast_q, rd_pend_q;
   logic [5:0]            rcv_q, exp_q, txw_q, txl_q, txl_d;
   logic                  buf_ready, buf_valid;
   logic [15:0]           buf_word;

   // line state decode from the dual-rail pair
   wire pos_s    = manchester_rx_pair.pos & ~manchester_rx_pair.neg;
   wire neg_s    = manchester_rx_pair.neg & ~manchester_rx_pair.pos;
   wire line_act = pos_s | neg_s;
   wire first_s  = sync_cmd_q ? pos_s : neg_s;
   wire second_s = sync_cmd_q ? neg_s : pos_s;
   wire bit_end  = (rx_q == RX_BITS) && (cyc_q == `MTP_CYC_DN(`MTP_BIT_NS) - 10'h001);
   wire last_bit = nbit_q == 5'(`MTP_WORD_BITS - 1);

   // received word decode
   wire [15:0] wrd      = shift_q[16:1];
   wire        word_err = man_q | ~mtp_odd_ok(shift_q);
   wire        addr_hit = addr_ok_q & ((wrd[`MTP_F_ADDR] == addr_q) |
                                       (wrd[`MTP_F_ADDR] == `MTP_BCAST_ADDR));
   wire        is_mode  = (wrd[`MTP_F_SUB] == `MTP_SUB_MODE_LO) |
                          (wrd[`MTP_F_SUB] == `MTP_SUB_MODE_HI);
   wire [5:0]  cnt_w    = (wrd[`MTP_F_CNT] == 5'h00) ? `MTP_MAX_WORDS : {1'b0, wrd[`MTP_F_CNT]};

   // message events
   wire cmd_ev   = word_v_q & sync_cmd_q & role_select & addr_hit;
   wire cmd_ok   = cmd_ev & ~word_err;
   wire cmd_err  = cmd_ev & word_err;
   wire stat_ev  = word_v_q & sync_cmd_q & ~role_select;
   wire data_ev  = word_v_q & ~sync_cmd_q & in_msg_q;
   wire push     = cmd_ok | stat_ev | data_ev;
   wire msg_end  = in_msg_q & (gap_q == `MTP_CYC_UP(`MTP_GAP_NS));
   wire end_err  = msg_err_q | (rcv_q != exp_q);
   wire tx_start = msg_end & role_select & ~end_err & ~bcast_q;
   wire tx_wend  = (txl_q != 6'h00) && (txc_q == `MTP_CYC_DN(`MTP_TX_WORD_NS) - 10'h001);
   wire rd_set   = (tx_start & (txw_q != 6'h00)) | (tx_wend & (txl_q > 6'h02));
   wire rd_taken = (dm_q == DM_RD) & mem_ack;
   wire [3:0] err_new = {push & ~buf_ready,
                         msg_end & (rcv_q != exp_q),
                         (data_ev | stat_ev) & man_q,
                         (data_ev | stat_ev) & ~mtp_odd_ok(shift_q)};

   // response word count: status word plus requested data words
   assign txl_d = tx_start ? 6'(txw_q + 6'h01) :
                  tx_wend  ? 6'(txl_q - 6'h01) : txl_q;

   // receiver sequencing: sync search, then timed bit sampling
   always_comb begin
      rx_d  = rx_q;
      cyc_d = `MTP_TW'(cyc_q + 10'h001);
      unique case (rx_q)
         RX_IDLE: begin
            cyc_d = 10'h001;
            if (line_act) rx_d = RX_SYNC_A;
         end
         RX_SYNC_A: begin
            if (second_s && cyc_q >= `MTP_CYC_UP(`MTP_SYNC_MIN_NS)) begin
               rx_d  = RX_SYNC_B;
               cyc_d = 10'h001;
            end else if (!first_s || cyc_q > `MTP_CYC_DN(`MTP_SYNC_MAX_NS)) begin
               rx_d = RX_IDLE;
            end
         end
         RX_SYNC_B: begin
            if (cyc_q == `MTP_CYC_DN(`MTP_SYNC_HALF_NS)) begin
               rx_d  = RX_BITS;
               cyc_d = 10'h000;
            end else if (!second_s && cyc_q < `MTP_CYC_UP(`MTP_SYNC_MIN_NS)) begin
               rx_d = RX_IDLE;
            end
         end
         RX_BITS: begin
            if (bit_end) begin
               cyc_d = 10'h000;
               if (last_bit) rx_d = RX_IDLE;
            end
         end
      endcase
   end

   // receiver registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_q <= RX_IDLE;
         cyc_q <= '0;
         nbit_q <= '0;
         shift_q <= '0;
         sync_cmd_q <= 1'b0;
         h1_q <= 1'b0;
         man_q <= 1'b0;
         word_v_q <= 1'b0;
      end else begin
         rx_q     <= rx_d;
         cyc_q    <= cyc_d;
         word_v_q <= bit_end & last_bit;
         if (rx_q == RX_IDLE) begin
            sync_cmd_q <= pos_s;
            nbit_q     <= '0;
            if (line_act) man_q <= 1'b0;
         end
         if (rx_q == RX_BITS && cyc_q == `MTP_CYC_DN(`MTP_SAMPLE1_NS)) h1_q <= pos_s;
         if (rx_q == RX_BITS && cyc_q == `MTP_CYC_DN(`MTP_SAMPLE2_NS) &&
             (pos_s == h1_q || !line_act)) man_q <= 1'b1;
         if (bit_end) begin
            shift_q <= {shift_q[15:0], h1_q};
            nbit_q  <= 5'(nbit_q + 5'h01);
         end
      end
   end

   // terminal address, valid only after a load since reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         addr_q    <= '0;
         addr_ok_q <= 1'b0;
      end else if (rt_address_load) begin
         addr_q    <= rt_address;
         addr_ok_q <= 1'b1;
      end
   end

   // message tracking and gap timer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         in_msg_q <= 1'b0;
         msg_err_q <= 1'b0;
         bcast_q <= 1'b0;
         rcv_q <= '0;
         exp_q <= '0;
         txw_q <= '0;
         gap_q <= '0;
      end else begin
         if (cmd_ok | stat_ev) begin
            in_msg_q  <= 1'b1;
            msg_err_q <= stat_ev & word_err;
            bcast_q   <= stat_ev | (wrd[`MTP_F_ADDR] == `MTP_BCAST_ADDR);
            rcv_q     <= '0;
            exp_q     <= (stat_ev | wrd[`MTP_F_TR]) ? 6'h00 : cnt_w;
            txw_q     <= (cmd_ok & wrd[`MTP_F_TR]) ? cnt_w : 6'h00;
         end else begin
            if (data_ev) rcv_q <= 6'(rcv_q + 6'h01);
            if (data_ev & word_err) msg_err_q <= 1'b1;
            if (msg_end) in_msg_q <= 1'b0;
         end
         if (rx_q != RX_IDLE || word_v_q) gap_q <= '0;
         else if (in_msg_q && !msg_end) gap_q <= `MTP_TW'(gap_q + 10'h001);
      end
   end

   // status outputs and sticky error flags
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         valid_command_pulse <= 1'b0;
         message_complete_n  <= 1'b1;
         invalid_message_n   <= 1'b1;
         mode_command_flag   <= 1'b0;
         error_flags         <= '0;
      end else begin
         valid_command_pulse <= cmd_ok;
         message_complete_n  <= ~msg_end;
         invalid_message_n   <= ~(cmd_err | (msg_end & end_err));
         if (cmd_ok) mode_command_flag <= is_mode;
         error_flags <= (cmd_ok ? 4'h0 : error_flags) | err_new;
      end
   end

   // response transmit window and data read requests
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         txl_q <= '0;
         txc_q <= '0;
         rd_pend_q <= 1'b0;
         transmit_active <= 1'b0;
      end else begin
         txl_q <= txl_d;
         txc_q <= (tx_start | tx_wend) ? 10'h000 : `MTP_TW'(txc_q + 10'h001);
         transmit_active <= txl_d != 6'h00;
         rd_pend_q <= rd_set | (rd_pend_q & ~rd_taken);
      end
   end

   mtp_buf #(.W(16), .DEPTH(2)) u_buf (
      .clk       (mclk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (wrd),
      .out_valid (buf_valid),
      .out_ready (dm_q == DM_STB),
      .out_data  (buf_word)
   );

   // memory transfers: writes drain the buffer, reads fetch response data
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dm_q    <= DM_IDLE;
         mem_q   <= '{data: 16'h0000, oe: 1'b0, we_n: 1'b1, rd_wr: 1'b0, req: 1'b0};
         tx_word <= '0;
      end else begin
         unique case (dm_q)
            DM_IDLE: begin
               if (buf_valid) begin
                  mem_q.data  <= buf_word;
                  mem_q.oe    <= 1'b1;
                  mem_q.rd_wr <= 1'b0;
                  mem_q.req   <= 1'b1;
                  dm_q        <= DM_WR;
               end else if (rd_pend_q) begin
                  mem_q.rd_wr <= 1'b1;
                  mem_q.req   <= 1'b1;
                  dm_q        <= DM_RD;
               end
            end
            DM_WR: if (mem_ack) begin
               mem_q.we_n <= 1'b0;
               dm_q       <= DM_STB;
            end
            DM_STB: begin
               mem_q.we_n <= 1'b1;
               mem_q.oe   <= 1'b0;
               mem_q.req  <= 1'b0;
               dm_q       <= DM_IDLE;
            end
            DM_RD: if (mem_ack) begin
               tx_word     <= mem_din;
               mem_q.rd_wr <= 1'b0;
               mem_q.req   <= 1'b0;
               dm_q        <= DM_IDLE;
            end
         endcase
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_bus_own;
      $fell(mem_q.oe) |-> !$past(mem_q.we_n) && !mem_q.rd_wr;
   endproperty
   property p_bus_own2;
      mem_q.oe |-> (dm_q == DM_WR || dm_q == DM_STB);
   endproperty
   property p_tx_flag;
      tx_start |=> transmit_active [*8];
   endproperty
   property p_err_clear;
      disable iff (1'b0) !rst_n |=> error_flags == 4'h0;
   endproperty
   property p_mode_flag;
      (cmd_ok && is_mode) |=> mode_command_flag && valid_command_pulse;
   endproperty
   property p_we_stable;
      !mem_q.we_n |-> mem_q.oe && $stable(mem_q.data) && $past(mem_q.oe);
   endproperty
   property p_vc_pulse;
      valid_command_pulse |=> !valid_command_pulse;
   endproperty
   property p_dir;
      (dm_q == DM_RD) |-> mem_q.rd_wr && !mem_q.oe;
   endproperty
   property p_im_mc;
      (msg_end && end_err) |=> !invalid_message_n && !message_complete_n;
   endproperty
   property p_cmd_err;
      cmd_err |=> !invalid_message_n && message_complete_n && rx_q != RX_BITS;
   endproperty
   property p_mc_end;
      msg_end |=> !message_complete_n ##1 message_complete_n;
   endproperty
   property p_reset_idle;
      disable iff (1'b0) !rst_n |=> mem_q.we_n && !mem_q.oe && !transmit_active
                                    && invalid_message_n && message_complete_n;
   endproperty

   a_bus_own:    assert property (p_bus_own)    else $error("bus driven outside write");
   a_bus_own2:   assert property (p_bus_own2)   else $error("bus enable in wrong state");
   a_tx_flag:    assert property (p_tx_flag)    else $error("transmit flag dropped");
   a_err_clear:  assert property (p_err_clear)  else $error("errors not cleared");
   a_mode_flag:  assert property (p_mode_flag)  else $error("mode flag missing");
   a_we_stable:  assert property (p_we_stable)  else $error("strobe with unstable data");
   a_vc_pulse:   assert property (p_vc_pulse)   else $error("valid command too long");
   a_dir:        assert property (p_dir)        else $error("read direction wrong");
   a_im_mc:      assert property (p_im_mc)      else $error("error not with complete");
   a_cmd_err:    assert property (p_cmd_err)    else $error("command error handling");
   a_mc_end:     assert property (p_mc_end)     else $error("complete pulse wrong");
   a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset");

   c_valid_cmd: cover property (valid_command_pulse);
   c_msg_done:  cover property (!message_complete_n && invalid_message_n);
   c_write:     cover property (!mem_q.we_n);
   c_read:      cover property (rd_taken);
endmodule : mtp_terminal

// ==== shared/mtp_defs.svh ====
`ifndef MTP_DEFS_SVH
`define MTP_DEFS_SVH

// clock rate and derived cycle counts
`define MTP_CLK_MHZ       25
`define MTP_TW            10
`define MTP_CYC_DN(ns)    10'(((ns) * `MTP_CLK_MHZ) / 1000)
`define MTP_CYC_UP(ns)    10'((((ns) * `MTP_CLK_MHZ) + 999) / 1000)

// serial timing in ns
`define MTP_BIT_NS        1000
`define MTP_SYNC_MIN_NS   1200
`define MTP_SYNC_HALF_NS  1500
`define MTP_SYNC_MAX_NS   1800
`define MTP_SAMPLE1_NS    250
`define MTP_SAMPLE2_NS    750
`define MTP_GAP_NS        4000
`define MTP_TX_WORD_NS    20000

// word layout
`define MTP_WORD_BITS     17
`define MTP_F_ADDR        15:11
`define MTP_F_TR          10
`define MTP_F_SUB         9:5
`define MTP_F_CNT         4:0
`define MTP_BCAST_ADDR    5'h1F
`define MTP_SUB_MODE_LO   5'h00
`define MTP_SUB_MODE_HI   5'h1F
`define MTP_MAX_WORDS     6'h20

// error flag positions
`define MTP_E_PARITY      0
`define MTP_E_MANCH       1
`define MTP_E_COUNT       2
`define MTP_E_OVERRUN     3

`endif

// ==== shared/mtp_pkg.sv ====
package mtp_pkg;

   typedef struct packed {
      logic pos;
      logic neg;
   } mtp_rx_pair_t;

   typedef struct packed {
      logic [15:0] data;
      logic        oe;
      logic        we_n;
      logic        rd_wr;
      logic        req;
   } mtp_mem_out_t;

   typedef enum logic [3:0] {
      RX_IDLE   = 4'b0001,
      RX_SYNC_A = 4'b0010,
      RX_SYNC_B = 4'b0100,
      RX_BITS   = 4'b1000
   } mtp_rx_state_t;

   typedef enum logic [3:0] {
      DM_IDLE = 4'b0001,
      DM_WR   = 4'b0010,
      DM_STB  = 4'b0100,
      DM_RD   = 4'b1000
   } mtp_dma_state_t;

   function automatic logic mtp_odd_ok(input logic [16:0] w);
      return ^w;
   endfunction : mtp_odd_ok

endpackage : mtp_pkg

// ==== test/mtp_mem_model.sv ====
`timescale 1ns/1ps
// memory and dma partner: grants each pending cycle after a chosen latency
module mtp_mem_model (
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic                  stall,
   input  wire logic [1:0]            lat,
   input  wire logic [15:0]           rd_value,
   input  wire mtp_pkg::mtp_mem_out_t mem_q,
   output logic                       mem_ack,
   output logic [15:0]                mem_din
);
   import mtp_pkg::*;
   logic       busy_q;
   logic [1:0] wait_q;
   // one-cycle grant, then wait for the request to drop before the next
   always @(negedge mclk) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         mem_din <= 16'h0000;
         busy_q  <= 1'b0;
         wait_q  <= lat;
      end else begin
         mem_din <= ~mem_din; // no stale read data outside a grant
         if (mem_ack) begin
            mem_ack <= 1'b0;
            busy_q  <= mem_q.req; // a read has dropped its request already
            wait_q  <= lat;
         end else if (busy_q) begin
            if (!mem_q.req) busy_q <= 1'b0;
         end else if (mem_q.req && !stall) begin
            if (wait_q == 2'h0) begin
               mem_ack <= 1'b1;
               mem_din <= rd_value;
            end else begin
               wait_q <= wait_q - 2'h1;
            end
         end
      end
   end
endmodule : mtp_mem_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import mtp_pkg::*;
   typedef struct packed {
      logic [2:0]  kind;
      logic [31:0] val;
   } mtp_ev_t;
   localparam logic [4:0] RA = 5'h0A;
   logic          mclk, rst_n, role_select, rt_address_load, mem_ack, stall, mon_on;
   logic          vc_pend, txs;
   mtp_rx_pair_t  pair;
   logic [4:0]    rt_address;
   logic [15:0]   mem_din, rd_value, tx_word;
   logic [1:0]    lat;
   logic [3:0]    error_flags;
   mtp_mem_out_t  mem_q;
   logic          transmit_active, mode_command_flag, valid_command_pulse;
   logic          invalid_message_n, message_complete_n;
   int            miscompares, checked, tx_len, wr_cnt;
   int            seed = 32'hEE47AB40;
   mtp_ev_t       q[$];

   // clock
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   mtp_terminal dut (.mclk, .rst_n, .manchester_rx_pair(pair), .role_select, .rt_address,
      .rt_address_load, .mem_ack, .mem_din, .mem_q, .transmit_active, .mode_command_flag,
      .valid_command_pulse, .invalid_message_n, .message_complete_n, .error_flags, .tx_word);

   mtp_mem_model mem (.mclk, .rst_n, .stall, .lat, .rd_value, .mem_q, .mem_ack, .mem_din);

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic note(input logic [2:0] k, input logic [31:0] v);
      q.push_back('{k, v});
   endtask : note

   // compare an observed event with the oldest note
   task automatic post(input logic [2:0] k, input logic [31:0] v);
      mtp_ev_t e;
      e = (q.size() == 0) ? mtp_ev_t'{3'h7, 32'h0} : q.pop_front();
      check("event kind", 32'(e.kind), 32'(k));
      check("event value", e.val, v);
   endtask : post

   task automatic drive(input logic [1:0] v, input int n);
      pair = v;
      repeat (n) @(negedge mclk);
   endtask : drive

   // sync, 16 bits msb first, odd parity (bad flips it)
   task automatic send_word(input logic cs, input logic [15:0] w, input logic bad);
      logic [16:0] b;
      b = {w, ~^w ^ bad};
      drive({cs, ~cs}, 37);
      drive({~cs, cs}, 37);
      for (int i = 16; i >= 0; i--) begin
         drive({b[i], ~b[i]}, 12);
         drive({~b[i], b[i]}, 13);
      end
      drive(2'h0, 1);
   endtask : send_word

   task automatic cmd_msg(input logic [4:0] a, input logic tr, input logic [4:0] sub,
                          input logic [4:0] cnt, input int nd, input int txc);
      logic [15:0] c;
      logic [15:0] d;
      logic        hit;
      c = {a, tr, sub, cnt};
      hit = (a == RA) || (a == 5'h1F);
      lat = 2'($random(seed));
      if (hit) note(3'h0, 32'(sub == 5'h00 || sub == 5'h1F));
      if (hit) note(3'h1, {16'h0002, c});
      send_word(1'b1, c, 1'b0);
      for (int i = 0; i < nd; i++) begin
         d = 16'($random(seed));
         if (hit) note(3'h1, {16'h0002, d});
         send_word(1'b0, d, 1'b0);
      end
      // broadcast ends clean but sends no response
      if (hit) note(3'h2, 32'(txc != 0 || a == 5'h1F));
      if (hit && txc != 0) note(3'h4, 32'(txc));
      drive(2'h0, 150 + txc);
   endtask : cmd_msg

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge mclk);
      check("oe in reset", 32'h0, 32'(mem_q.oe));
      check("we_n in reset", 32'h1, 32'(mem_q.we_n));
      check("tx in reset", 32'h0, 32'(transmit_active));
      check("pulses in reset", 32'h3, 32'({valid_command_pulse, message_complete_n,
                                           invalid_message_n}));
      check("flags in reset", 32'h0, 32'(error_flags));
      rst_n = 1'b1;
      @(negedge mclk);
   endtask : do_reset

   task automatic load_addr();
      rt_address = RA;
      rt_address_load = 1'b1;
      @(negedge mclk);
      rt_address_load = 1'b0;
   endtask : load_addr

   // output monitor: every observed event takes the oldest note
   always @(negedge mclk) begin
      if (rst_n && mem_q.we_n === 1'b0) wr_cnt++;
      if (!rst_n || !mon_on) begin
         vc_pend = 1'b0;
         tx_len = 0;
      end else begin
         if (vc_pend) post(3'h0, 32'(mode_command_flag));
         vc_pend = (valid_command_pulse === 1'b1);
         if (mem_q.we_n === 1'b0) post(3'h1, {14'h0, mem_q.oe, mem_q.rd_wr, mem_q.data});
         if (message_complete_n === 1'b0) post(3'h2, 32'(invalid_message_n));
         else if (invalid_message_n === 1'b0) post(3'h3, 32'h0);
         if (transmit_active === 1'b1) begin
            tx_len++;
         end else if (tx_len != 0) begin
            post(3'h4, 32'(tx_len));
            tx_len = 0;
         end
      end
   end

   // watchdog
   initial begin
      #3000000;
      miscompares++;
      $display("watchdog expired");
      finish_test();
   end

   // main sequence
   initial begin
      pair = 2'h0;
      {rst_n, rt_address_load, stall, lat, rt_address} = '0;
      {role_select, mon_on} = 2'h3;
      rd_value = 16'h0000;
      do_reset();
      load_addr();
      cmd_msg(RA, 1'b0, 5'h01, 5'h01, 1, 500);
      $display("test receive done");
      cmd_msg(RA, 1'b0, 5'h00, 5'h00, 0, 0);
      cmd_msg(RA, 1'b0, 5'h1F, 5'h00, 0, 0);
      check("count flag", 32'h1, 32'(error_flags[2]));
      $display("test mode commands done");
      rd_value = 16'($random(seed));
      cmd_msg(RA, 1'b1, 5'h02, 5'h01, 0, 1000);
      check("tx_word", 32'(rd_value), 32'(tx_word));
      $display("test transmit done");
      cmd_msg(RA ^ 5'h01, 1'b0, 5'h01, 5'h01, 1, 500);
      cmd_msg(5'h1F, 1'b0, 5'h05, 5'h01, 1, 0);
      $display("test other address done");
      note(3'h3, 32'h0);
      send_word(1'b1, {RA, 1'b0, 5'h01, 5'h01}, 1'b1);
      drive(2'h0, 150);
      cmd_msg(RA, 1'b0, 5'h03, 5'h01, 1, 500);
      $display("test bad command done");
      mon_on = 1'b0;
      role_select = 1'b0;
      txs = 1'b0;
      send_word(1'b1, {RA, 1'b0, 5'h01, 5'h00}, 1'b0);
      repeat (700) begin
         @(negedge mclk);
         txs = txs | transmit_active;
      end
      check("controller role tx", 32'h0, 32'(txs));
      role_select = 1'b1;
      $display("test controller role done");
      stall = 1'b1;
      wr_cnt = 0;
      send_word(1'b1, {RA, 1'b0, 5'h01, 5'h02}, 1'b0);
      send_word(1'b0, 16'h1234, 1'b0);
      send_word(1'b0, 16'h5678, 1'b0);
      drive(2'h0, 150);
      check("overrun flag", 32'h1, 32'(error_flags[3]));
      stall = 1'b0;
      drive(2'h0, 300);
      check("drained writes", 32'h2, 32'(wr_cnt));
      $display("test overrun done");
      do_reset();
      mon_on = 1'b1;
      send_word(1'b1, {RA, 1'b0, 5'h01, 5'h01}, 1'b0);
      drive(2'h0, 200);
      load_addr();
      cmd_msg(RA, 1'b0, 5'h04, 5'h01, 1, 500);
      $display("test reload done");
      check("notes left", 32'h0, 32'(q.size()));
      finish_test();
   end
endmodule : tb_top
